// ---- rtl/pss_params.svh ----
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH
`define PSS_OFFSET        6'h02
`define PSS_RESET_VALUE   16'h0010
`define PSS_BIT_TRI_CTRL  11
`define PSS_BIT_INHIBIT   10
`define PSS_BIT_HOT       9
`define PSS_BIT_TRISTATED 8
`define PSS_MODE_HI       7
`define PSS_MODE_LO       5
`define PSS_BIT_FB        4
`define PSS_BIT_FA        3
`define PSS_BIT_EN_OK     2
`define PSS_BIT_MSG_BAD   1
`define PSS_BIT_PAR       0
`define PSS_MODE_RSVD     3'h7
`endif

// ---- rtl/pss_pkg.sv ----
package pss_pkg;
  typedef logic [2:0]  pss_mode_type;
  typedef logic [15:0] pss_word_type;
  typedef logic [5:0]  pss_addr_type;
endpackage

// ---- rtl/pss_status_reg.sv ----
// Contract
// [R01] bit 11 mirrors secondary tristate control
// [R02] bit 10 high during shoot-through inhibit
// [R03] bit 9 mirrors secondary over-temperature
// [R04] bit 8 high while output tristated
// [R05] bits 7:5 mirror secondary mode code
// [R06] bit 4 sticky fault b pin request
// [R07] bit 3 sticky fault a pin request
// [R08] bit 2 shows enable input validity
// [R09] bit 1 flags last message discarded
// [R10] bit 0 makes word parity odd
// [R11] upper bits zero, writes ignored
`timescale 1ns/1ps
`include "pss_params.svh"
module pss_status_reg (
  input  wire logic                  ref_clk,              // 25 MHz clock
  input  wire logic                  reset_n,              // async reset
  input  wire logic                  tristate_ctrl_mirror, // secondary ctrl
  input  wire logic                  shoot_through_inhibit,// inhibit live
  input  wire logic                  overtemp_flag,        // secondary ot
  input  wire logic                  output_tristated,     // secondary hz
  input  wire pss_pkg::pss_mode_type op_mode,              // secondary mode
  input  wire logic                  fault_b_drive_req,    // pin b low req
  input  wire logic                  fault_a_drive_req,    // pin a low req
  input  wire logic                  fault_clr,            // clear stickies
  input  wire logic                  enable_valid,         // enable judged ok
  input  wire logic                  last_msg_invalid,     // msg discarded
  input  wire logic                  rd_en,                // read strobe
  input  wire logic                  wr_en,                // write strobe
  input  wire pss_pkg::pss_addr_type addr,                 // register index
  output logic                       rd_hit,               // read matched
  output pss_pkg::pss_word_type      rd_data               // read word
);
  import pss_pkg::*;

  // sticky request flags live in the helper module at the bottom
  logic         fb_r;      // sticky pin b request
  logic         fa_r;      // sticky pin a request
  logic         fb_nxt;    // pin b flag as it will be latched
  logic         fa_nxt;    // pin a flag as it will be latched
  pss_word_type stat_r;    // live word snapshot
  pss_word_type stat_nxt;  // word built from this cycle's inputs
  pss_word_type rd_data_r; // held read answer
  logic         rd_hit_r;  // read match flag

  // address decode; only the one index answers
  wire sel    = (addr == `PSS_OFFSET); // register picked
  wire rd_sel = rd_en && sel;          // read taken this edge
  // writes are decoded only so the checks below can watch them
  wire wr_sel = wr_en && sel;          // write attempt, dropped // [R11]

  // pin b request flag; reset shows it set, as the reset word does
  pss_sticky_bit #(
    .RESET_VAL (1'h1)
  ) fb_flag (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .set_req  (fault_b_drive_req),
    .clr_req  (fault_clr),
    .flag_nxt (fb_nxt),
    .flag_r   (fb_r)
  ); // [R06]

  // pin a request flag; starts clear
  pss_sticky_bit #(
    .RESET_VAL (1'h0)
  ) fa_flag (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .set_req  (fault_a_drive_req),
    .clr_req  (fault_clr),
    .flag_nxt (fa_nxt),
    .flag_r   (fa_r)
  ); // [R07]

  // word assembly by field position, so the bit map lives in one header;
  // the sticky fields use the next value so a set shows in the same edge
  always_comb begin
    // reserved bits and anything not named below read as zero
    stat_nxt = '0; // [R11]
    stat_nxt[`PSS_BIT_TRI_CTRL]  = tristate_ctrl_mirror;  // [R01]
    stat_nxt[`PSS_BIT_INHIBIT]   = shoot_through_inhibit; // [R02]
    stat_nxt[`PSS_BIT_HOT]       = overtemp_flag;         // [R03]
    stat_nxt[`PSS_BIT_TRISTATED] = output_tristated;      // [R04]
    // reserved mode code passes through; the far side owns its meaning
    stat_nxt[`PSS_MODE_HI:`PSS_MODE_LO] = op_mode; // [R05]
    stat_nxt[`PSS_BIT_FB]        = fb_nxt;                // [R06]
    stat_nxt[`PSS_BIT_FA]        = fa_nxt;                // [R07]
    stat_nxt[`PSS_BIT_EN_OK]     = enable_valid;          // [R08]
    stat_nxt[`PSS_BIT_MSG_BAD]   = last_msg_invalid;      // [R09]
    // parity last, over everything above it, so the ones count is odd
    stat_nxt[`PSS_BIT_PAR]       = ~(^stat_nxt[15:1]);    // [R10]
  end

  // status snapshot every cycle; a write has no path in here on purpose
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_r <= `PSS_RESET_VALUE;
    end else begin
      stat_r <= stat_nxt; // [R11]
    end
  end

  // read answer registered so outputs come from flops;
  // costs one cycle of latency but keeps the pins glitch free
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_r <= 16'h0000;
      rd_hit_r  <= 1'h0;
    end else begin
      rd_hit_r  <= rd_sel;
      // data bus idles at zero so a missed strobe never shows a word
      rd_data_r <= rd_sel ? stat_r : 16'h0000; // [R11]
    end
  end

  // outputs straight from the read flops
  assign rd_data = rd_data_r;
  assign rd_hit  = rd_hit_r;

  // checks all run on the logic clock and sleep through reset
  default clocking ast_cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // the held word always has an odd ones count
  AST_PARITY_ODD: assert property ( // [R10]
    ^stat_r == 1'h1)
    else $error("status word parity not odd");

  AST_RSVD_ZERO: assert property ( // [R11]
    rd_hit |-> rd_data[15:12] == 4'h0)
    else $error("reserved bits set");

  // mirrored fields follow their source one edge later
  AST_TRI_CTRL: assert property ( // [R01]
    1'h1 |=> stat_r[11] == $past(tristate_ctrl_mirror))
    else $error("tristate control mirror wrong");

  AST_INHIBIT_SET: assert property ( // [R02]
    shoot_through_inhibit |=> stat_r[10])
    else $error("inhibit status missing");

  AST_INHIBIT_CLEAR: assert property ( // [R02]
    !shoot_through_inhibit |=> !stat_r[10])
    else $error("inhibit status stuck");

  AST_HOT_CLEAR: assert property ( // [R03]
    !overtemp_flag |=> !stat_r[9])
    else $error("overtemp status stuck");

  AST_HOT_SET: assert property ( // [R03]
    overtemp_flag |=> stat_r[9])
    else $error("overtemp status missing");

  AST_TRISTATED: assert property ( // [R04]
    1'h1 |=> stat_r[8] == $past(output_tristated))
    else $error("tristate status wrong");

  AST_MODE: assert property ( // [R05]
    1'h1 |=> stat_r[7:5] == $past(op_mode))
    else $error("mode field wrong");

  // a one-cycle request survives until a clear comes
  AST_FB_STICKY: assert property ( // [R06]
    fault_b_drive_req ##1 (!fault_clr && !fault_b_drive_req) |=> stat_r[4])
    else $error("fault b not sticky");

  AST_FB_CLEAR: assert property ( // [R06]
    fault_clr && !fault_b_drive_req |=> !fb_r)
    else $error("fault b not cleared");

  AST_FA_STICKY: assert property ( // [R07]
    fault_a_drive_req |=> fa_r ##0 stat_r[3])
    else $error("fault a lost");

  // a set in the very cycle of a clear must win
  AST_FA_SET_WINS: assert property ( // [R07]
    fault_a_drive_req && fault_clr |=> fa_r)
    else $error("fault a lost to clear");

  AST_EN_OK_LOW: assert property ( // [R08]
    !enable_valid |=> !stat_r[2])
    else $error("enable valid stuck");

  AST_EN_OK_HIGH: assert property ( // [R08]
    enable_valid |=> stat_r[2])
    else $error("enable valid missing");

  AST_MSG_BAD: assert property ( // [R09]
    last_msg_invalid |=> stat_r[1])
    else $error("discard flag missing");

  AST_MSG_OK: assert property ( // [R09]
    !last_msg_invalid |=> !stat_r[1])
    else $error("discard flag stuck");

  // read answer comes exactly one edge after the strobe
  AST_READ: assert property ( // [R11]
    rd_en && sel |=> rd_hit && rd_data == $past(stat_r))
    else $error("read data mismatch");

  AST_READ_IDLE: assert property ( // [R11]
    !(rd_en && sel) |=> !rd_hit && rd_data == 16'h0000)
    else $error("answer without a read");

  // a write attempt changes nothing: the word still follows the inputs
  AST_WRITE_IGNORED: assert property ( // [R11]
    wr_sel |=> stat_r == $past(stat_nxt))
    else $error("write altered the word");
endmodule

// one sticky request flag; a set in the clear cycle is kept
module pss_sticky_bit #(
  parameter logic RESET_VAL = 1'h0 // level shown straight out of reset
) (
  input  wire logic ref_clk,  // logic clock
  input  wire logic reset_n,  // async reset
  input  wire logic set_req,  // request seen this cycle
  input  wire logic clr_req,  // clear pulse
  output logic      flag_nxt, // value the flop takes next
  output logic      flag_r    // held flag
);
  // set beats clear so a fault raised during a clear is never lost
  assign flag_nxt = set_req | (flag_r & ~clr_req);

  // reset branch loads the constant only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_r <= RESET_VAL;
    end else begin
      flag_r <= flag_nxt;
    end
  end
endmodule

// ---- bench/pss_host.sv ----
`timescale 1ns/1ps
// stand-in for the spi host that polls the status word
module pss_host (
  input  wire logic                  ref_clk,  // logic clock
  input  wire logic                  req,      // bench asks for a read
  input  wire pss_pkg::pss_addr_type req_addr, // index wanted
  output logic                       rd_en,    // one-cycle read strobe
  output pss_pkg::pss_addr_type      addr      // index on the bus
);
  import pss_pkg::*;
  // launch after the edge so strobe and index stay put a full cycle;
  // an idle bus shows the inverse index, never a stale match
  always_ff @(posedge ref_clk) begin
    rd_en <= req;
    addr  <= req ? req_addr : ~req_addr;
  end
endmodule

// ---- bench/primary_second_status_reg_tb.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  mismatches++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module primary_second_status_reg_tb;
  import pss_pkg::*;
  logic         ref_clk = 0, reset_n = 0, clr = 0, wr = 0, req = 0;
  logic [10:0]  v = '0;      // live fields in word order, bits 11:1
  pss_addr_type ra = 6'h02;  // index the host is asked for
  logic         rd_en, hit;  // strobe and answer
  pss_addr_type addr;        // index seen by the register
  pss_word_type dat;         // returned word
  int           mismatches = 0, check_count = 0;
  initial forever #20 ref_clk = ~ref_clk;
  pss_host host (.ref_clk(ref_clk), .req(req), .req_addr(ra),
    .rd_en(rd_en), .addr(addr));
  pss_status_reg uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .tristate_ctrl_mirror(v[10]), .shoot_through_inhibit(v[9]),
    .overtemp_flag(v[8]), .output_tristated(v[7]), .op_mode(v[6:4]),
    .fault_b_drive_req(v[3]), .fault_a_drive_req(v[2]), .fault_clr(clr),
    .enable_valid(v[1]), .last_msg_invalid(v[0]), .rd_en(rd_en),
    .wr_en(wr), .addr(addr), .rd_hit(hit), .rd_data(dat));
  // expected word: reserved zero, fields, odd parity in bit 0
  function automatic pss_word_type w(input logic [10:0] f);
    return {4'h0, f, ~^f};
  endfunction
  // one read through the host; answer lands one cycle after the strobe
  task automatic rd(input pss_addr_type a, input logic h,
                    input pss_word_type e);
    @(posedge ref_clk) req <= 1'b1;
    ra <= a;
    @(posedge ref_clk) req <= 1'b0;
    @(posedge ref_clk) #1;
    `CHK(hit, h)
    `CHK(dat, e)
  endtask
  // writes and foreign indexes must leave the word alone
  task automatic t_refuse();
    @(posedge ref_clk) wr <= 1'b1;
    rd(6'h03, 1'b0, 16'h0000);
    rd(6'h02, 1'b1, 16'h0010);
    @(posedge ref_clk) wr <= 1'b0;
  endtask
  // a one-cycle request must stick until cleared; set beats clear
  task automatic t_sticky();
    @(posedge ref_clk) clr <= 1'b1;
    @(posedge ref_clk) clr <= 1'b0;
    rd(6'h02, 1'b1, 16'h0001);
    @(posedge ref_clk) v[3] <= 1'b1;
    @(posedge ref_clk) v[3] <= 1'b0;
    rd(6'h02, 1'b1, 16'h0010);
    @(posedge ref_clk) v[2] <= 1'b1;
    clr <= 1'b1;
    @(posedge ref_clk) v[2] <= 1'b0;
    clr <= 1'b0;
    rd(6'h02, 1'b1, 16'h0008);
  endtask
  // mid-run reset: answer drops at once, word returns to its start
  task automatic t_reset();
    @(posedge ref_clk) reset_n <= 1'b0;
    v <= '0;
    @(posedge ref_clk) #1;
    `CHK(hit, 1'b0)
    `CHK(dat, 16'h0000)
    @(posedge ref_clk) reset_n <= 1'b1;
    rd(6'h02, 1'b1, 16'h0010);
  endtask
  // every mode code, reserved one too, with fault requests held high, tristate control low, the other flags varied
  task automatic t_fields();
    logic [10:0] nv;
    for (int i = 0; i < 8; i++) begin
      nv = {4'(i) ^ 4'h5, 3'(i), 2'b11, 2'(i)};
      @(posedge ref_clk) v <= nv;
      rd(6'h02, 1'b1, w(nv));
      rd(6'h02, 1'b1, w(nv));
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog: the whole run needs about 92 cycles, far below the 2000-cycle limit
  initial begin
    repeat (2000) @(posedge ref_clk);
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(6'h02, 1'b1, 16'h0010);
    t_refuse();
    t_sticky();
    t_fields();
    t_reset();
    give_verdict();
  end
endmodule
